//--- adcsa_pkg.sv
// shared constants and types for the stand-alone converter link
package adcsa_pkg;
  localparam int ADCSA_CLK_MHZ = 40;
  localparam int ADCSA_CLK_NS = 25;
  localparam int ADCSA_RES_W = 12;
  localparam int ADCSA_BUS_W = 16;
  // device timing in ns; the host wait in us
  localparam int ADCSA_STS_RISE_MAX_NS = 600;
  localparam int ADCSA_STS_FALL_MIN_NS = 300;
  localparam int ADCSA_STS_FALL_MAX_NS = 1000;
  localparam int ADCSA_HOLD_MIN_NS = 25;
  localparam int ADCSA_FLOAT_MAX_NS = 150;
  localparam int ADCSA_LOW_PULSE_MIN_NS = 250;
  localparam int ADCSA_HIGH_PULSE_MIN_NS = 300;
  localparam int ADCSA_WAIT_US = 35;
  // cycle counts: least times round up, longest times round down
  localparam int ADCSA_HOLD_CYC = (ADCSA_HOLD_MIN_NS + ADCSA_CLK_NS - 1) / ADCSA_CLK_NS;
  localparam int ADCSA_FLOAT_CYC = ADCSA_FLOAT_MAX_NS / ADCSA_CLK_NS;
  localparam int ADCSA_STS_RISE_CYC = ADCSA_STS_RISE_MAX_NS / ADCSA_CLK_NS;
  localparam int ADCSA_STS_FALL_CYC =
    (ADCSA_STS_FALL_MIN_NS + ADCSA_CLK_NS - 1) / ADCSA_CLK_NS;
  localparam int ADCSA_LOW_PULSE_CYC =
    (ADCSA_LOW_PULSE_MIN_NS + ADCSA_CLK_NS - 1) / ADCSA_CLK_NS;
  localparam int ADCSA_HIGH_PULSE_CYC =
    (ADCSA_HIGH_PULSE_MIN_NS + ADCSA_CLK_NS - 1) / ADCSA_CLK_NS;
  localparam int ADCSA_WAIT_CYC = ADCSA_WAIT_US * ADCSA_CLK_MHZ;
  // default conversion lengths in cycles
  localparam int ADCSA_CONV12_CYC = 1400;
  localparam int ADCSA_CONV8_CYC = 960;
  localparam int ADCSA_CNT_W = 16;
  // host register map
  localparam logic [3:0] ADCSA_REG_CTRL = 4'h0;
  localparam logic [3:0] ADCSA_REG_STAT = 4'h1;
  localparam logic [3:0] ADCSA_REG_DATA = 4'h2;
  localparam logic [3:0] ADCSA_REG_MODE = 4'h3;
  localparam int ADCSA_CTRL_START = 0;
  localparam int ADCSA_CTRL_SHORT = 1;
  localparam int ADCSA_STAT_BUSY = 0;
  localparam int ADCSA_STAT_DONE = 1;
  localparam int ADCSA_STAT_CONV = 2;
  localparam int ADCSA_MODE_WIDE = 0;
  localparam int ADCSA_MODE_POLL = 1;
  localparam logic [3:0] ADCSA_ZERO_NIB = 4'h0;
  typedef enum {HS_IDLE, HS_LOW, HS_WAIT, HS_RD1, HS_RD2, HS_GAP} adcsa_hstate_t;
  typedef enum {DS_IDLE, DS_FLOAT, DS_CONV, DS_DONE} adcsa_dstate_t;
endpackage

//--- adcsa_if.sv
// pin-level link between converter and host
`timescale 1ns/1ps
interface adcsa_if;
  logic chip_enable;
  logic select_n;
  logic wide_bus;
  logic byte_select;
  logic read_convert;
  logic conversion_status;
  logic [11:0] result;
  logic result_oe;
  modport device (input chip_enable, input select_n, input wide_bus, input byte_select,
    input read_convert, output conversion_status, output result, output result_oe);
  modport host (output chip_enable, output select_n, output wide_bus, output byte_select,
    output read_convert, input conversion_status, input result, input result_oe);
endinterface

//--- adcsa_dev.sv
// converter end: stand-alone conversion control and three-state result outputs
// Behaviour
// - host wires enable/width high, select/byte low; here width is a mode bit, byte high for short starts and second bytes
// - outputs driven while line high; fall starts
// - low pulse: float at fall, drive after conversion
// - status rises within 600ns, falls 300-1000ns after data valid
// - high pulse: drive only while line high
// - host holds low 250ns, high 300ns
// - keep old data 25ns, float within 150ns
// - host starts by write, reads after completion
// - status shows conversion in progress to host
// - host may instead wait 35 microseconds
// - wide bus gives all twelve bits
// - narrow bus left-justified bytes, zeros trailing
// - no right-justified byte layout exists
// - sixteen-bit host wires wide, byte low; this host still raises byte for short starts
// - fast hosts stretch pulses with wait states
// - strobe with decode starts; status latches result
// - direction plus decode starts; strobe acknowledges
// - decoded port gates select; strobes drive enable
// - wait states bound supported host speed
// - busy device ignores starts and outputs
// - byte-select chooses twelve or eight bit cycle
// - status high from start to completion
`timescale 1ns/1ps
module adcsa_dev
  import adcsa_pkg::*;
#(
  // default lengths suit the real part; a bench may shrink them
  parameter int CONV12_CYC = ADCSA_CONV12_CYC,
  parameter int CONV8_CYC = ADCSA_CONV8_CYC
) (
  input wire logic CLK,
  input wire logic RSTN,
  adcsa_if.device LNK,
  input wire logic [11:0] SAMPLE
);
  // pins come from the other chip: two flops before any logic reads them
  logic [1:0] rc_s;
  logic [1:0] ce_s;
  logic [1:0] cs_s;
  logic [1:0] ab_s;
  logic [1:0] wb_s;
  logic rc_q;
  logic en_q;
  logic sel_q;
  logic abyte_q;
  logic wide_q;
  // one down-counter serves the hold, the conversion and the status tail
  adcsa_dstate_t st_q;
  logic [ADCSA_CNT_W-1:0] cnt_q;
  // result word as captured, and as laid out for the pins
  logic [11:0] res_q;
  logic sts_q;
  logic sts_d;
  logic oe_q;
  logic [11:0] out_q;
  logic [11:0] out_d;
  logic fall;
  logic active;
  logic show;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rc_s <= '0;
      ce_s <= '0;
      cs_s <= 2'b11;
      ab_s <= '0;
      wb_s <= '0;
    end else begin
      rc_s <= {rc_s[0], LNK.read_convert};
      ce_s <= {ce_s[0], LNK.chip_enable};
      cs_s <= {cs_s[0], LNK.select_n};
      ab_s <= {ab_s[0], LNK.byte_select};
      wb_s <= {wb_s[0], LNK.wide_bus};
    end
  end

  // a third stage keeps the last level so the fall detector has a previous value
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rc_q <= 1'b0;
      en_q <= 1'b0;
      sel_q <= 1'b0;
      abyte_q <= 1'b0;
      wide_q <= 1'b0;
    end else begin
      rc_q <= rc_s[1];
      en_q <= ce_s[1];
      sel_q <= ~cs_s[1];
      abyte_q <= ab_s[1];
      wide_q <= wb_s[1];
    end
  end

  // stand-alone strapping: enable high and select low gate starts and the output enable
  assign active = en_q & sel_q;
  // rc_q resets low, so the idle-high line cannot look like a fall after reset
  assign fall = active & rc_q & ~rc_s[1];
  // data may be shown once the count has expired, during the status tail too
  assign show = (st_q == DS_IDLE) | (st_q == DS_DONE);

  // conversion sequencer; edges seen while busy are dropped
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= DS_IDLE;
      cnt_q <= '0;
    end else begin
      case (st_q)
        DS_IDLE: begin
          if (fall) begin
            st_q <= DS_FLOAT;
            // the hold count delays the conversion start; enable has already dropped on this edge
            cnt_q <= ADCSA_CNT_W'(ADCSA_HOLD_CYC);
          end
        end
        DS_FLOAT: begin
          if (cnt_q <= ADCSA_CNT_W'(1)) begin
            st_q <= DS_CONV;
            // byte-select at start picks the cycle length
            cnt_q <= abyte_q ? ADCSA_CNT_W'(CONV8_CYC) : ADCSA_CNT_W'(CONV12_CYC);
          end else begin
            cnt_q <= cnt_q - ADCSA_CNT_W'(1);
          end
        end
        DS_CONV: begin
          if (cnt_q <= ADCSA_CNT_W'(1)) begin
            st_q <= DS_DONE;
            cnt_q <= ADCSA_CNT_W'(ADCSA_STS_FALL_CYC);
          end else begin
            cnt_q <= cnt_q - ADCSA_CNT_W'(1);
          end
        end
        DS_DONE: begin
          // status held past data valid by the minimum gap
          // a fall on the line here is still refused, status is high
          if (cnt_q <= ADCSA_CNT_W'(1)) begin
            st_q <= DS_IDLE;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q - ADCSA_CNT_W'(1);
          end
        end
        default: begin
          st_q <= DS_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // result captured only when the count expires
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      res_q <= '0;
    end else if (st_q == DS_CONV && cnt_q <= ADCSA_CNT_W'(1)) begin
      res_q <= abyte_q ? {SAMPLE[11:4], ADCSA_ZERO_NIB} : SAMPLE;
    end
  end

  // status rises one cycle after the edge is seen, well inside 600 ns
  assign sts_d = (st_q != DS_IDLE) | fall;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sts_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
    end
  end

  // outputs: old data held a cycle after the fall then floated
  // the fall term drops enable at once instead of waiting for the state change
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= active & rc_q & show & ~fall;
    end
  end

  // data layout: wide gives the whole word, narrow left-justified bytes
  always_comb begin
    out_d = out_q;
    if (show) begin
      if (wide_q) begin
        out_d = res_q;
      end else if (abyte_q) begin
        // the low nibble sits in the upper half of the byte lane, zeros below
        out_d = {ADCSA_ZERO_NIB, res_q[3:0], ADCSA_ZERO_NIB};
      end else begin
        out_d = {res_q[11:8], res_q[11:4]};
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign LNK.conversion_status = sts_q;
  assign LNK.result = out_q;
  assign LNK.result_oe = oe_q;
endmodule

//--- adcsa_host.sv
// host end: starts conversions, waits or polls status, reads the result
`timescale 1ns/1ps
module adcsa_host
  import adcsa_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  adcsa_if.host LNK,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA
);
  adcsa_hstate_t st_q;
  logic [ADCSA_CNT_W-1:0] cnt_q;
  logic rc_q, ab_q, short_q, wide_q, poll_q;
  logic [15:0] res_q, rdata_q;
  logic [1:0] sts_s;
  logic sts_q;
  logic start;

  assign start = WR & (ADDR == ADCSA_REG_CTRL) & WDATA[ADCSA_CTRL_START];

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sts_s <= '0;
      sts_q <= 1'b0;
    end else begin
      sts_s <= {sts_s[0], LNK.conversion_status};
      sts_q <= sts_s[1];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wide_q <= 1'b1;
      poll_q <= 1'b1;
    end else if (WR && ADDR == ADCSA_REG_MODE) begin
      wide_q <= WDATA[ADCSA_MODE_WIDE];
      poll_q <= WDATA[ADCSA_MODE_POLL];
    end
  end

  // low pulse on the line starts, then wait or poll, then read
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= HS_IDLE;
      cnt_q <= '0;
      rc_q <= 1'b1;
      ab_q <= 1'b0;
      short_q <= 1'b0;
      res_q <= '0;
    end else begin
      case (st_q)
        HS_IDLE: begin
          if (start) begin
            st_q <= HS_LOW;
            rc_q <= 1'b0;
            short_q <= WDATA[ADCSA_CTRL_SHORT];
            ab_q <= WDATA[ADCSA_CTRL_SHORT];
            cnt_q <= ADCSA_CNT_W'(ADCSA_LOW_PULSE_CYC);
          end
        end
        HS_LOW: begin
          if (cnt_q <= ADCSA_CNT_W'(1)) begin
            st_q <= HS_WAIT;
            rc_q <= 1'b1;
            cnt_q <= ADCSA_CNT_W'(ADCSA_WAIT_CYC);
          end else begin
            cnt_q <= cnt_q - ADCSA_CNT_W'(1);
          end
        end
        HS_WAIT: begin
          // poll for the falling status edge, or time out after 35 us
          if ((poll_q && cnt_q < ADCSA_CNT_W'(ADCSA_WAIT_CYC - ADCSA_STS_RISE_CYC) &&
               !sts_q) || cnt_q <= ADCSA_CNT_W'(1)) begin
            st_q <= HS_RD1;
            ab_q <= 1'b0;
            cnt_q <= ADCSA_CNT_W'(ADCSA_HIGH_PULSE_CYC);
          end else begin
            cnt_q <= cnt_q - ADCSA_CNT_W'(1);
          end
        end
        HS_RD1: begin
          if (cnt_q <= ADCSA_CNT_W'(1)) begin
            if (wide_q) begin
              res_q <= {4'h0, LNK.result}; // upper four bits zero-filled
              st_q <= HS_IDLE;
            end else begin
              res_q <= {4'h0, LNK.result[7:0], ADCSA_ZERO_NIB};
              st_q <= short_q ? HS_IDLE : HS_GAP;
              ab_q <= ~short_q;
              cnt_q <= ADCSA_CNT_W'(ADCSA_HIGH_PULSE_CYC);
            end
          end else begin
            cnt_q <= cnt_q - ADCSA_CNT_W'(1);
          end
        end
        HS_GAP: begin
          st_q <= HS_RD2;
        end
        HS_RD2: begin
          // second byte: low nibble sits in the upper half
          if (cnt_q <= ADCSA_CNT_W'(1)) begin
            res_q[3:0] <= LNK.result[7:4];
            ab_q <= 1'b0;
            st_q <= HS_IDLE;
          end else begin
            cnt_q <= cnt_q - ADCSA_CNT_W'(1);
          end
        end
        default: begin
          st_q <= HS_IDLE;
          rc_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= '0;
    end else if (RD) begin
      case (ADDR)
        ADCSA_REG_STAT: rdata_q <= {13'h0000, sts_q, st_q == HS_IDLE, st_q != HS_IDLE};
        ADCSA_REG_DATA: rdata_q <= res_q;
        ADCSA_REG_MODE: rdata_q <= {14'h0000, poll_q, wide_q};
        default: rdata_q <= '0;
      endcase
    end
  end

  // stand-alone strapping
  assign LNK.chip_enable = 1'b1;
  assign LNK.select_n = 1'b0;
  assign LNK.wide_bus = wide_q;
  assign LNK.byte_select = ab_q;
  assign LNK.read_convert = rc_q;
  assign RDATA = rdata_q;
endmodule

//--- adcsa_asserts.sv
// timing and format checks on the converter link
`timescale 1ns/1ps
module adcsa_asserts (
  input logic CLK,
  input logic RSTN,
  input logic chip_enable,
  input logic select_n,
  input logic wide_bus,
  input logic byte_select,
  input logic read_convert,
  input logic conversion_status,
  input logic [11:0] result,
  input logic result_oe
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // 600 ns at 25 ns a cycle
  a_status_rise_bound: assert property (
    $fell(read_convert) && !conversion_status |-> ##[1:24] conversion_status)
    else $error("status late");
  a_old_data_hold: assert property (
    $fell(read_convert) && $past(result_oe) |-> result_oe)
    else $error("no hold");
  a_float_deadline: assert property (
    $fell(read_convert) |-> ##[0:6] !result_oe)
    else $error("no float");
  // outputs come up during the status tail only: 300 ns to 1000 ns before status drops
  a_busy_late_output: assert property (
    conversion_status && $rose(result_oe) |->
      conversion_status [*8] ##1 conversion_status [*4] ##[1:29] !conversion_status)
    else $error("output early in conversion");
  a_low_line_floats: assert property (
    !read_convert [*7] |-> !result_oe)
    else $error("oe low");
  // result must have settled 300 ns before status drops; margin kept for the register stage
  a_status_fall_gap: assert property (
    $fell(conversion_status) |-> result == $past(result, 10))
    else $error("early fall");
  // the pins lag a byte-select or width change by the synchroniser and register stages
  a_narrow_tail: assert property (
    (byte_select && !wide_bus) [*5] ##0 result_oe |-> result[3:0] == 4'h0)
    else $error("tail");
  a_host_ties: assert property (
    chip_enable && !select_n)
    else $error("ties");
  a_low_pulse_width: assert property (
    $fell(read_convert) |-> !read_convert [*8] ##1 !read_convert [*2])
    else $error("low short");
  a_high_pulse_width: assert property (
    $rose(read_convert) |-> read_convert [*8] ##1 read_convert [*4])
    else $error("high short");
  cover property ($fell(conversion_status));
  cover property (result_oe && !wide_bus && byte_select);
  cover property ($fell(read_convert) && byte_select);
  cover property (conversion_status && $rose(result_oe));
endmodule

//--- adcsa_test.sv
// bench joining host and converter ends through the link
`timescale 1ns/1ps
module adcsa_test;
  import adcsa_pkg::*;
  logic CLK;
  logic RSTN;
  logic [3:0] ADDR;
  logic [15:0] WDATA;
  logic WR;
  logic RD;
  logic [15:0] RDATA;
  logic [11:0] SAMPLE;
  int failures;
  int num_checks;
  int hi_cnt;
  int t_long;
  int t_short;
  logic [15:0] v;

  adcsa_if adcsa_if_i();
  adcsa_dev #(.CONV12_CYC(20), .CONV8_CYC(12)) adcsa_dev_i (.CLK(CLK), .RSTN(RSTN),
    .LNK(adcsa_if_i), .SAMPLE(SAMPLE));
  adcsa_host adcsa_host_i (.CLK(CLK), .RSTN(RSTN), .LNK(adcsa_if_i), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
  adcsa_asserts adcsa_asserts_i (.CLK(CLK), .RSTN(RSTN), .chip_enable(adcsa_if_i.chip_enable),
    .select_n(adcsa_if_i.select_n), .wide_bus(adcsa_if_i.wide_bus),
    .byte_select(adcsa_if_i.byte_select), .read_convert(adcsa_if_i.read_convert),
    .conversion_status(adcsa_if_i.conversion_status), .result(adcsa_if_i.result),
    .result_oe(adcsa_if_i.result_oe));

  always #12.5 CLK = ~CLK;
  // busy length measured on the wire, independent of host bookkeeping
  always @(posedge CLK) begin
    if (adcsa_if_i.conversion_status === 1'b1) begin
      hi_cnt++;
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask

  // one conversion: optional second start while busy must be ignored
  task automatic run(input logic [15:0] mode, input logic [15:0] ctrl, input logic [11:0] s,
      input logic dup, output int len);
    int n;
    int c0;
    logic [15:0] st;
    c0 = hi_cnt;
    wr(ADCSA_REG_MODE, mode);
    SAMPLE <= s;
    wr(ADCSA_REG_CTRL, ctrl);
    rd(ADCSA_REG_STAT, st);
    chk("busy", st & 16'h0001, 16'h0001);
    if (dup) begin
      wr(ADCSA_REG_CTRL, ctrl);
    end
    st = 16'h0000;
    for (n = 0; n < 3000 && st[ADCSA_STAT_DONE] !== 1'b1; n++) begin
      rd(ADCSA_REG_STAT, st);
    end
    len = hi_cnt - c0;
    if (st[ADCSA_STAT_DONE] !== 1'b1) begin
      failures++;
      $display("[FAIL] idle wait expected 1 seen %b", st[ADCSA_STAT_DONE]);
      give_verdict();
    end
    chk("status low", st & 16'h0004, 16'h0000);
  endtask

  initial begin
    CLK = 1'b0;
    RSTN = 1'b0;
    ADDR = 4'h0;
    WDATA = 16'h0000;
    WR = 1'b0;
    RD = 1'b0;
    SAMPLE = 12'h000;
    failures = 0;
    num_checks = 0;
    hi_cnt = 0;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    rd(ADCSA_REG_MODE, v);
    chk("mode reset", v, 16'h0003);
    rd(ADCSA_REG_STAT, v);
    chk("stat reset", v & 16'h0007, 16'h0002);
    rd(ADCSA_REG_DATA, v);
    chk("data reset", v, 16'h0000);
    $display("test reset done");
    run(16'h0003, 16'h0001, 12'hA5C, 1'b1, t_long);
    rd(ADCSA_REG_DATA, v);
    chk("wide data", v, 16'h0A5C);
    $display("test wide done");
    run(16'h0003, 16'h0003, 12'h5A3, 1'b0, t_short);
    // busy time differs only by the conversion length
    chk("short len", 16'(t_long - t_short), 16'h0008);
    rd(ADCSA_REG_DATA, v);
    chk("short data", v, 16'h05A0);
    $display("test short done");
    run(16'h0002, 16'h0001, 12'h3C7, 1'b0, t_short);
    rd(ADCSA_REG_DATA, v);
    chk("narrow data", v, 16'h03C7);
    $display("test narrow done");
    run(16'h0001, 16'h0001, 12'h81E, 1'b0, t_short);
    rd(ADCSA_REG_DATA, v);
    chk("timed data", v, 16'h081E);
    $display("test timed done");
    give_verdict();
  end
endmodule
